// ### hdl/dma_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "dma_engine_defines.vh"

// ************************************************************
// Word FIFO between the byte packer and the bus engine
// ************************************************************
module word_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = 2
) (
  input  wire             clk_sys,
  input  wire             reset_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_push;
  wire            do_pop;

  // Full and empty come straight from the count
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  // Storage has no reset; only pointers and count are reset
  always @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and count update
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push & ~do_pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (do_pop & ~do_push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ************************************************************
// Five-channel bus-master DMA engine
// ************************************************************
module dma_engine (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        big_endian,
  input  wire        burst_eight,
  input  wire        shared_memory,
  input  wire        split_enable,
  input  wire [7:0]  header_len,
  input  wire [4:0]  frame_per_page,
  input  wire [4:0]  chan_enable,
  input  wire [19:0] class_mask,
  input  wire [4:0]  ptr_load,
  input  wire [27:0] ptr_load_value,
  input  wire        xlat_we,
  input  wire [3:0]  xlat_index,
  input  wire [15:0] xlat_frame,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_first,
  input  wire        rx_last,
  input  wire        rx_mac_smt,
  input  wire [1:0]  rx_class,
  output reg         rx_ready,
  input  wire [1:0]  tx_req,
  input  wire [1:0]  tx_frame_done,
  output reg         tx_valid,
  output reg  [31:0] tx_data,
  output reg         tx_chan,
  output reg         bus_req,
  input  wire        bus_grant,
  output reg  [31:0] ad_out,
  output reg         ad_oe,
  input  wire [31:0] ad_in,
  output reg  [3:0]  par_out,
  input  wire [3:0]  par_in,
  output reg  [27:0] addr_out,
  output reg  [2:0]  addr_low,
  output reg         addr_strobe,
  output reg         data_strobe,
  output reg         write_cycle,
  input  wire        bus_ack,
  input  wire        parity_clear,
  output reg         parity_error,
  output reg  [2:0]  active_chan
);
  localparam S_IDLE = 2'h0;
  localparam S_REQ  = 2'h1;
  localparam S_ADDR = 2'h2;
  localparam S_DATA = 2'h3;

  // Odd parity for each byte lane
  function [3:0] parity4;
    input [31:0] w;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        parity4[k] = (^w[8*k +: 8]) ^ `PAR_ODD;
      end
    end
  endfunction

  // Reverse the byte lanes of a word
  function [31:0] swap32;
    input [31:0] w;
    begin
      swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction

  reg  [27:0] ptr_reg [0:4];
  reg  [15:0] xlat_reg [0:15];
  reg  [1:0]  state_reg;
  reg  [2:0]  cur_ch_reg;
  reg         prio_tx_reg;
  reg  [3:0]  words_left_reg;
  reg         cur_last_reg;
  reg  [1:0]  byte_idx_reg;
  reg  [31:0] word_reg;
  reg  [7:0]  frame_cnt_reg;

  wire [35:0] fifo_in;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [35:0] fifo_out;
  reg         fifo_pop;
  wire [2:0]  fifo_level;

  // Byte routing for the current receive byte
  reg  [7:0]  cnt_now;
  reg  [2:0]  rx_ch;
  reg         keep;
  reg         hdr_end;
  reg         push;
  reg  [1:0]  lane;
  reg  [31:0] word_next;

  always @* begin
    cnt_now = rx_first ? 8'h00 : frame_cnt_reg;
    if (rx_mac_smt) begin
      rx_ch = `CH_RX0;
    end else if (split_enable && (cnt_now >= header_len)) begin
      rx_ch = `CH_RX2;                                   // see RQ14
    end else begin
      rx_ch = `CH_RX1;                                   // see RQ16
    end
    keep    = chan_enable[rx_ch] &
              class_mask[{rx_ch[1:0], 2'b00} + {2'b00, rx_class}];  // see RQ12
    hdr_end = split_enable & ~rx_mac_smt &
              (cnt_now == header_len - 8'h01);
    push    = rx_valid & rx_ready & keep &
              ((byte_idx_reg == 2'h3) | rx_last | hdr_end);
    lane    = big_endian ? ~byte_idx_reg : byte_idx_reg;  // see RQ10
    word_next = (byte_idx_reg == 2'h0) ? 32'h00000000 : word_reg;
    word_next[{lane, 3'b000} +: 8] = rx_data;
  end

  assign fifo_in = {rx_last | hdr_end, rx_ch, word_next};

  word_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // Packer: at most one push per byte, so ready lags one cycle safely
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_ready      <= 1'b0;
      byte_idx_reg  <= 2'h0;
      word_reg      <= 32'h00000000;
      frame_cnt_reg <= 8'h00;
    end else begin
      rx_ready <= (fifo_level < 3'h3) & fifo_in_ready;
      if (rx_valid & rx_ready) begin
        frame_cnt_reg <= (cnt_now == 8'hFF) ? 8'hFF : cnt_now + 8'h01;
        if (keep) begin
          word_reg    <= word_next;
          byte_idx_reg <= (push) ? 2'h0 : byte_idx_reg + 2'h1;
        end
      end
    end
  end

  // Virtual to physical: small direct-mapped page table
  reg  [27:0] vaddr;
  reg  [27:0] paddr;
  reg  [3:0]  blk_words;
  reg  [3:0]  blk_idx;
  reg         rx_want;
  reg         tx_want;
  reg  [2:0]  pick_ch;
  reg  [2:0]  tx_ch;

  always @* begin
    vaddr     = ptr_reg[cur_ch_reg];
    paddr     = {xlat_reg[vaddr[15:12]], vaddr[11:0]};   // see RQ9
    blk_words = burst_eight ? `BURST_LONG : `BURST_SHORT; // see RQ3
    blk_idx   = burst_eight ? {1'b0, vaddr[4:2]} : {2'b00, vaddr[3:2]};
    rx_want   = fifo_out_valid;
    tx_ch     = (tx_req[0] & chan_enable[3]) ? `CH_TX0 : 3'h4;
    tx_want   = (tx_req[0] & chan_enable[3]) | (tx_req[1] & chan_enable[4]);
    if (rx_want & (~tx_want | ~prio_tx_reg)) begin
      pick_ch = fifo_out[34:32];
    end else begin
      pick_ch = tx_ch;
    end
  end

  // Translation table load
  always @(posedge clk_sys) begin
    if (xlat_we) begin
      xlat_reg[xlat_index] <= xlat_frame;
    end
  end

  // Bus engine: arbitration, address phase, burst data phase
  reg        more;
  reg        acked;
  reg [27:0] nxt_ptr;

  always @* begin
    acked    = (state_reg == S_DATA) & bus_ack;
    nxt_ptr  = vaddr + 28'h0000004;
    more     = (words_left_reg != 4'h1) & ~cur_last_reg &
               fifo_out_valid & (fifo_out[34:32] == cur_ch_reg);
    fifo_pop = 1'b0;
    if (write_cycle && (state_reg == S_ADDR)) begin
      fifo_pop = 1'b1;
    end else if (write_cycle && acked && more) begin
      fifo_pop = 1'b1;                                   // see RQ5
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= S_IDLE;
      cur_ch_reg     <= `CH_RX0;
      prio_tx_reg    <= 1'b0;
      words_left_reg <= 4'h0;
      cur_last_reg   <= 1'b0;
      bus_req        <= 1'b0;
      ad_out         <= 32'h00000000;
      ad_oe          <= 1'b0;
      par_out        <= 4'h0;
      addr_out       <= 28'h0000000;
      addr_low       <= 3'h0;
      addr_strobe    <= 1'b0;
      data_strobe    <= 1'b0;
      write_cycle    <= 1'b0;
      tx_valid       <= 1'b0;
      tx_data        <= 32'h00000000;
      tx_chan        <= 1'b0;
      parity_error   <= 1'b0;
      active_chan    <= 3'h0;
    end else begin
      tx_valid <= 1'b0;
      // Sticky read parity flag; a new error beats the clear
      if (acked & ~write_cycle & (par_in != parity4(ad_in))) begin
        parity_error <= 1'b1;                            // see RQ2
      end else if (parity_clear) begin
        parity_error <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (rx_want | tx_want) begin
            cur_ch_reg  <= pick_ch;
            active_chan <= pick_ch;
            write_cycle <= (pick_ch < `CH_TX0);
            prio_tx_reg <= ~prio_tx_reg;                 // see RQ11
            bus_req     <= ~shared_memory;               // see RQ15
            state_reg   <= S_REQ;
          end
        end
        S_REQ: begin
          // A private memory is always ours; a shared bus waits for grant
          if (shared_memory | bus_grant) begin
            ad_out         <= {4'h0, paddr};             // see RQ1
            par_out        <= parity4({4'h0, paddr});
            ad_oe          <= 1'b1;
            addr_out       <= paddr;
            addr_low       <= paddr[4:2];
            addr_strobe    <= 1'b1;
            words_left_reg <= blk_words - blk_idx;       // see RQ8
            state_reg      <= S_ADDR;
          end
        end
        S_ADDR: begin
          addr_strobe <= 1'b0;
          data_strobe <= 1'b1;
          ad_oe       <= write_cycle;
          if (write_cycle) begin
            ad_out       <= fifo_out[31:0];
            par_out      <= parity4(fifo_out[31:0]);
            cur_last_reg <= fifo_out[35];
          end else begin
            cur_last_reg <= 1'b0;
          end
          state_reg <= S_DATA;
        end
        S_DATA: begin
          // Word held until the far end acknowledges it
          if (bus_ack) begin                             // see RQ6
            addr_low       <= addr_low + 3'h1;           // see RQ4
            words_left_reg <= words_left_reg - 4'h1;
            if (~write_cycle) begin
              tx_valid <= 1'b1;
              tx_data  <= big_endian ? swap32(ad_in) : ad_in;
              tx_chan  <= cur_ch_reg[0] ^ 1'b1;
            end
            if (write_cycle & more) begin
              ad_out       <= fifo_out[31:0];
              par_out      <= parity4(fifo_out[31:0]);
              cur_last_reg <= fifo_out[35];
            end else if (~write_cycle & (words_left_reg != 4'h1)) begin
              cur_last_reg <= 1'b0;
            end else begin
              // Block edge, frame end or dry FIFO closes the burst
              state_reg   <= S_IDLE;                     // see RQ17
              data_strobe <= 1'b0;
              ad_oe       <= 1'b0;
              bus_req     <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Channel pointers: load, advance per word, page jump per frame
  integer c;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (c = 0; c < `NUM_CH; c = c + 1) begin
        ptr_reg[c] <= `PTR_RESET;
      end
    end else begin
      for (c = 0; c < `NUM_CH; c = c + 1) begin
        if (ptr_load[c]) begin
          ptr_reg[c] <= {ptr_load_value[27:2], 2'b00};
        end else if (acked && (cur_ch_reg == c)) begin
          if (frame_per_page[c] & write_cycle & cur_last_reg &
              (nxt_ptr[11:0] != 12'h000)) begin
            ptr_reg[c] <= {nxt_ptr[27:12] + 16'h0001, 12'h000};  // see RQ13
          end else begin
            ptr_reg[c] <= nxt_ptr;                       // see RQ7
          end
        end else if ((c >= 3) && tx_frame_done[c - 3] &&
                     frame_per_page[c] && (ptr_reg[c][11:0] != 12'h000)) begin
          ptr_reg[c] <= {ptr_reg[c][27:12] + 16'h0001, 12'h000};  // see RQ13
        end
      end
    end
  end
endmodule

`default_nettype wire

// ### pkg/dma_engine_defines.vh
// Overview of operation
// RQ1: 32-bit data, 28-bit address on data lines and on dedicated lines.
// RQ2: One parity bit per byte on the address/data path.
// RQ3: Bursts are programmable to four or eight 32-bit words.
// RQ4: Three low word address bits driven separately, updated every word.
// RQ5: One word per clock when the far end never waits.
// RQ6: Far end may insert waits; each word held until acknowledged.
// RQ7: No transaction crosses a page; structures stay inside one page.
// RQ8: Every transaction stays inside a naturally aligned burst block.
// RQ9: Buffer addresses translated through fixed-size pages.
// RQ10: Byte order within a word selectable big or little endian.
// RQ11: Five independent channels, two transmit and three receive.
// RQ12: Each channel accepts only its selected frame classes.
// RQ13: Per-channel choice of one frame per page or packed frames.
// RQ14: Split mode: header bytes to receive channel 1, rest to 2.
// RQ15: Works on a shared system bus or a private shared memory.
// RQ16: Frames not longer than the header go wholly to channel 1.
// RQ17: A burst meeting a boundary ends; the next starts there.
`ifndef DMA_ENGINE_DEFINES_VH
`define DMA_ENGINE_DEFINES_VH

`define ADDR_W        28
`define DATA_W        32
`define NUM_CH        5
`define CH_RX0        3'h0
`define CH_RX1        3'h1
`define CH_RX2        3'h2
`define CH_TX0        3'h3
`define PAGE_OFF_W    12
`define XLAT_IDX_W    4
`define XLAT_FRAME_W  16
`define CLASS_W       2
`define CLASS_N       4
`define BURST_SHORT   4'h4
`define BURST_LONG    4'h8
`define FIFO_DEPTH    4
`define FIFO_WIDTH    36
`define PAR_ODD       1'b1
`define PTR_RESET     28'h0000000

`endif

// ### tb/bus_memory.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Far-side memory with wait states
// ********************************
module bus_memory (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        bus_req,
  output var  logic        bus_grant,
  input  wire logic [27:0] addr_out,
  input  wire logic [2:0]  addr_low,
  input  wire logic        data_strobe,
  input  wire logic        write_cycle,
  input  wire logic [31:0] ad_out,
  input  wire logic [1:0]  stall,
  output wire logic        bus_ack,
  output wire logic [31:0] ad_in,
  output wire logic [3:0]  par_in
);
  logic [31:0] mem [0:4095];
  logic [1:0]  wait_reg;
  wire  [11:0] idx = {addr_out[13:5], addr_low};

  // Memory starts clear so untouched words read as zero
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 32'h0;
  end
  // Grant trails request by one cycle; writes land on the ack edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_grant <= 1'b0;
      wait_reg  <= 2'h0;
    end else begin
      bus_grant <= bus_req;
      wait_reg  <= (data_strobe && !bus_ack) ? wait_reg + 2'h1 : 2'h0;
      if (bus_ack && write_cycle) mem[idx] <= ad_out;
    end
  end
  // Zero stall gives one word per clock
  assign bus_ack = data_strobe && (wait_reg == stall);
  // Off the ack the lines carry the inverted word, never stale data
  assign ad_in  = bus_ack ? mem[idx] : ~mem[idx];
  assign par_in = {~^ad_in[31:24], ~^ad_in[23:16],
                   ~^ad_in[15:8], ~^ad_in[7:0]};
endmodule
`default_nettype wire

// ### tb/dma_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Bus cycle checks on engine pins
// ********************************
module dma_engine_asserts (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        shared_memory,
  input wire logic        burst_eight,
  input wire logic        bus_req,
  input wire logic        bus_grant,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic [3:0]  par_out,
  input wire logic [27:0] addr_out,
  input wire logic [2:0]  addr_low,
  input wire logic        addr_strobe,
  input wire logic        data_strobe,
  input wire logic        write_cycle,
  input wire logic        bus_ack,
  input wire logic        tx_valid
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Odd parity on every driven byte lane
  property p_par;
    ad_oe |-> par_out == {~^ad_out[31:24], ~^ad_out[23:16],
                          ~^ad_out[15:8], ~^ad_out[7:0]};
  endproperty
  a_par: assert property (p_par) else $error("bad byte parity");
  // Address phase carries the full address on both paths
  property p_mux;
    addr_strobe |-> ad_oe && ad_out == {4'h0, addr_out}
                    && addr_low == addr_out[4:2];
  endproperty
  a_mux: assert property (p_mux) else $error("bad address phase");
  property p_phase;
    addr_strobe |=> !addr_strobe && data_strobe;
  endproperty
  a_phase: assert property (p_phase) else $error("no data phase");
  // A stalled write word stays put until taken
  property p_hold;
    data_strobe && write_cycle && !bus_ack |=>
      data_strobe && $stable(ad_out) && $stable(addr_low);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_step;
    data_strobe && bus_ack ##1 data_strobe |->
      addr_low == $past(addr_low) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("low address");
  // Wrapping inside a burst would mean crossing an aligned block
  property p_blk;
    data_strobe && bus_ack ##1 data_strobe |->
      (burst_eight ? addr_low : {1'b0, addr_low[1:0]}) != 3'h0;
  endproperty
  a_blk: assert property (p_blk) else $error("block crossed");
  property p_addr;
    data_strobe |-> $stable(addr_out);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_share;
    shared_memory |-> !bus_req;
  endproperty
  a_share: assert property (p_share) else $error("request");
  property p_grant;
    addr_strobe && !shared_memory |-> $past(bus_grant);
  endproperty
  a_grant: assert property (p_grant) else $error("no grant");
  property p_tx;
    data_strobe && bus_ack && !write_cycle |=> tx_valid;
  endproperty
  a_tx: assert property (p_tx) else $error("read word lost");

  c_wr: cover property (data_strobe && bus_ack && write_cycle);
  c_rd: cover property (data_strobe && bus_ack && !write_cycle);
  c_wait: cover property (data_strobe && !bus_ack);
endmodule

bind dma_engine dma_engine_asserts chk (.*);
`default_nettype wire

// ### tb/dma_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dma_engine_bench;
  // ********************************
  // Stimulus, design and memory
  // ********************************
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        big_endian, burst_eight, shared_memory, split_enable;
  logic        xlat_we, rx_valid, rx_first, rx_last, rx_mac_smt;
  logic        parity_clear;
  logic [7:0]  header_len, rx_data;
  logic [4:0]  frame_per_page, chan_enable, ptr_load;
  logic [19:0] class_mask;
  logic [27:0] ptr_load_value;
  logic [3:0]  xlat_index;
  logic [15:0] xlat_frame;
  logic [1:0]  rx_class, tx_req, tx_frame_done, stall;
  wire         rx_ready, tx_valid, tx_chan, bus_req, bus_grant, ad_oe;
  wire         addr_strobe, data_strobe, write_cycle, bus_ack;
  wire         parity_error;
  wire  [31:0] tx_data, ad_out, ad_in;
  wire  [3:0]  par_out, par_in;
  wire  [27:0] addr_out;
  wire  [2:0]  addr_low, active_chan;
  int          num_errors = 0;
  int          checked = 0;
  int          n, t, t0;
  logic [31:0] e;

  dma_engine dut (.*);
  bus_memory far (.*);

  // Clock: 40 ns period
  always #20 clk_sys = ~clk_sys;

  // ********************************
  // Access tasks
  // ********************************
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail(input string s);
    num_errors++;
    $display("ERROR %0t: %s", $time, s);
    report_and_stop;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Word index in memory of a virtual address; table maps page p to p+1
  function automatic logic [11:0] ix(input logic [15:0] v);
    ix = {v[13:12] + 2'h1, v[11:2]};
  endfunction
  // n bytes counting up from b, zero padded, lanes per byte order
  function automatic logic [31:0] wd(input logic [7:0] b, input int n,
                                     input logic big);
    for (int k = 0; k < 4; k++)
      wd[(big ? 24 - 8 * k : 8 * k) +: 8] = (k < n) ? b + 8'(k) : 8'h00;
  endfunction
  task automatic ld(input int ch, input logic [27:0] v);
    ptr_load = 5'h01 << ch;
    ptr_load_value = v;
    tick;
    ptr_load = 5'h00;
    tick;
  endtask
  // Byte stream of one frame, honouring rx_ready
  task automatic frame(input int n, input logic mac, input logic [1:0] cls,
                       input logic [7:0] b);
    int w;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data = b + 8'(i);
      rx_first = (i == 0);
      rx_last = (i == n - 1);
      rx_mac_smt = mac;
      rx_class = cls;
      // Ready read between edges: it is what the next edge samples
      w = 0;
      while (rx_ready !== 1'b1 && w < 50) begin
        w++;
        tick;
      end
      if (w == 50) fail("rx stalled");
      tick;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
  endtask
  // Wait for eight quiet bus cycles in a row
  task automatic settle;
    int q, w;
    q = 0;
    w = 0;
    while (q < 8 && w < 400) begin
      tick;
      w++;
      q = (bus_req || addr_strobe || data_strobe) ? 0 : q + 1;
    end
    if (q < 8) fail("bus never idle");
  endtask

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    {big_endian, burst_eight, split_enable, xlat_we, rx_valid} = 5'h00;
    {rx_first, rx_last, rx_mac_smt, parity_clear} = 4'h0;
    {shared_memory, rx_data, rx_class, tx_req, tx_frame_done} = 15'h0000;
    {ptr_load, ptr_load_value, xlat_index, xlat_frame, stall} = 55'h0;
    header_len = 8'h03;
    frame_per_page = 5'h00;
    chan_enable = 5'h1F;
    class_mask = 20'hFFFFF;
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    tick;
    for (int i = 0; i < 5; i++) begin
      xlat_we = 1'b1;
      xlat_index = 4'(i);
      xlat_frame = 16'(i + 1);
      tick;
    end
    xlat_we = 1'b0;
    ld(0, 28'h000001C);
    ld(1, 28'h0001FFC);
    ld(2, 28'h0002100);
    ld(3, 28'h0000100);
    for (int k = 0; k < 4; k++)
      far.mem[ix(16'h0100) + 12'(k)] = 32'h13579BD0 + k;
    // Frame across a 4-word block edge on the system bus
    frame(8, 1'b1, 2'h0, 8'h10);
    settle;
    chk(far.mem[ix(16'h001C)], wd(8'h10, 4, 1'b0));
    chk(far.mem[ix(16'h0020)], wd(8'h14, 4, 1'b0));
    $display("test block edge done");
    // Big endian, 8-word blocks, private memory, two wait states
    {big_endian, burst_eight, shared_memory, stall} = 5'h1E;
    frame(8, 1'b1, 2'h1, 8'h20);
    settle;
    chk(far.mem[ix(16'h0024)], wd(8'h20, 4, 1'b1));
    chk(far.mem[ix(16'h0028)], wd(8'h24, 4, 1'b1));
    $display("test waits done");
    // Header split, then a short frame wholly to channel 1 on the next page
    {big_endian, stall, split_enable} = 4'h1;
    frame(6, 1'b0, 2'h1, 8'h30);
    settle;
    chk(far.mem[ix(16'h1FFC)], wd(8'h30, 3, 1'b0));
    chk(far.mem[ix(16'h2100)], wd(8'h33, 3, 1'b0));
    frame(2, 1'b0, 2'h1, 8'h40);
    settle;
    chk(far.mem[ix(16'h2000)], wd(8'h40, 2, 1'b0));
    chk(far.mem[ix(16'h2104)], 32'h0);
    $display("test split done");
    // Masked class is dropped, enabled class delivered
    split_enable = 1'b0;
    class_mask = 20'hFFFFB;
    frame(4, 1'b1, 2'h2, 8'h50);
    settle;
    chk(far.mem[ix(16'h002C)], 32'h0);
    class_mask = 20'hFFFFF;
    frame_per_page = 5'h01;
    frame(4, 1'b1, 2'h3, 8'h60);
    settle;
    chk(far.mem[ix(16'h002C)], wd(8'h60, 4, 1'b0));
    // One frame per page: the next frame opens a fresh page
    frame(4, 1'b1, 2'h0, 8'h70);
    settle;
    chk(far.mem[ix(16'h1000)], wd(8'h70, 4, 1'b0));
    chk(far.mem[ix(16'h0030)], 32'h0);
    frame_per_page = 5'h00;
    $display("test filter done");
    // Transmit read burst on the system bus at full speed, big endian
    {big_endian, burst_eight, shared_memory} = 3'h4;
    n = 0;
    t = 0;
    t0 = 0;
    tx_req = 2'h1;
    while (n < 4 && t < 200) begin
      tick;
      t++;
      if (tx_valid === 1'b1) begin
        if (n == 0) t0 = t;
        e = 32'h13579BD0 + 32'(n);
        chk(tx_data, {e[7:0], e[15:8], e[23:16], e[31:24]});
        chk(32'(t - t0), 32'(n));
        chk({31'h0, tx_chan}, 32'h0);
        n++;
      end
    end
    #1;
    tx_req = 2'h0;
    if (n < 4) fail("no read data");
    settle;
    chk({29'h0, active_chan}, 32'h3);
    chk({31'h0, parity_error}, 32'h0);
    $display("test read done");
    report_and_stop;
  end
endmodule
`default_nettype wire
